/* File: rtl/cpu_wr_pkg.sv */
// constants, carrier types and states of the processor-side bus write path
// ----------------------------------------------------------------------------
// How it works
// - long data gate asserts first rising edge after latch strobe falls, releases half clock late
// - long data gate active on writes per the write mask bit; read mask bit not used
// - long data gate pin is software-switchable; comes out of reset as input
// - write starts next rising edge when buffer pending, bus idle, nothing higher pending
// - non-empty buffer keeps requesting; further stores fill free entries until full
// - opening edge asserts store strobe, drives address, raises address latch strobe
// - normal mode swaps data in at strobe fall; long mode holds address a full clock
// - same-page hint computed and driven during every write address phase
// - hint asserts only on match of bits 31:8 with no read or DMA since
// - data appears second phase of first clock, or first phase of second clock
// - latch strobe falls as address leaves, or half clock before in long mode; then data driven, termination watched
// - memory pulse asserts one clock in, releases half clock after each acknowledge
// - peripheral pulse asserts 1.5 clocks in, holds to end, never in short writes
// - fail ends write exactly like final acknowledge; no exception, no retry
// - fail sampled with every acknowledge and wins; unsent data abandoned
// - final-datum flag asserts with strobe for single writes, else after next-to-last ack
// - next operation may start one clock after the final acknowledge
// - bus stays driven through the write into the next; no turnaround
// - store into full buffer stalls core until an entry frees, then fixup retries
// - started write moves to holding register; its entry frees at once
// - four entries of one 32-bit word, one store each
// ----------------------------------------------------------------------------
package cpu_wr_pkg;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned LANES    = 4;
  localparam int unsigned WB_DEPTH = 4;
  localparam int unsigned PAGE_LSB = 8;
  localparam int unsigned PAGE_W   = ADDR_W - PAGE_LSB;
  localparam int unsigned LO_W     = 4;

  // port width codes per store
  localparam logic [1:0] PW_32 = 2'h0;
  localparam logic [1:0] PW_16 = 2'h1;
  localparam logic [1:0] PW_8  = 2'h2;

  // pin direction control: bit set means the pin is an output
  localparam int unsigned DIR_GATE_BIT = 0;
  localparam int unsigned DIR_PERI_BIT = 1;
  localparam logic [1:0]  DIR_RESET    = 2'h0;

  localparam logic       LONG_MODE_RESET = 1'b0;
  localparam logic [2:0] ONE_DATUM       = 3'h1;
  localparam logic [3:0] STEP_HALF       = 4'h2;
  localparam logic [3:0] STEP_BYTE       = 4'h1;

  typedef struct packed {
    logic rd;
    logic wr;
  } strobe_mask_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  lanes_n;
    logic [1:0]        width;
  } wb_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } wr_state_t;
endpackage

/* File: rtl/cpu_bus_write_interface.sv */
// write buffer and multiplexed address/data bus write engine
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_write_interface
  import cpu_wr_pkg::*;
#(
  parameter int unsigned DEPTH = WB_DEPTH
) (
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  // core store port
  input  wire logic              store_valid_i,
  input  wire wb_entry_t         store_entry_i,
  output logic                   store_stall_o,
  output logic                   store_fixup_o,
  output logic                   buffer_pending_o,
  output logic                   buffer_drained_o,
  // arbitration with the rest of the bus unit
  input  wire logic              hi_prio_req_i,
  input  wire logic              ext_busy_i,
  input  wire logic              read_or_dma_seen_i,
  output logic                   wr_busy_o,
  // configuration
  input  wire logic              long_address_mode_i,
  input  wire logic [1:0]        pin_direction_ctrl_i,
  input  wire strobe_mask_t      gate_mask_i,
  input  wire strobe_mask_t      mem_mask_i,
  input  wire strobe_mask_t      periph_mask_i,
  // bus pins
  output logic [DATA_W-1:0]      ad_o,
  output logic                   ad_oe_o,
  output logic                   ale_o,
  output logic                   wr_n_o,
  output logic [LO_W-1:0]        addr_lo_o,
  output logic                   last_n_o,
  output logic                   same_page_hint_n_o,
  output logic                   memory_pulse_n_o,
  input  wire logic              periph_pulse_n_i,
  output logic                   periph_pulse_n_o,
  output logic                   periph_pulse_n_oe_o,
  input  wire logic              long_data_gate_n_i,
  output logic                   long_data_gate_n_o,
  output logic                   long_data_gate_n_oe_o,
  input  wire logic              ack_n_i,
  input  wire logic              transfer_fail_n_i
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

  // --------------------------------------------------------------------------
  // decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic [2:0] datum_count(input wb_entry_t e);
    logic [2:0] n;
    n = ONE_DATUM;
    unique case (e.width)
      PW_16: n = {2'h0, ~&e.lanes_n[3:2]} + {2'h0, ~&e.lanes_n[1:0]};
      PW_8:  n = {2'h0, ~e.lanes_n[3]} + {2'h0, ~e.lanes_n[2]}
               + {2'h0, ~e.lanes_n[1]} + {2'h0, ~e.lanes_n[0]};
      default: n = ONE_DATUM;
    endcase
    return (n == 3'h0) ? ONE_DATUM : n;
  endfunction

  function automatic logic [1:0] first_lane(input wb_entry_t e);
    logic [1:0] f;
    f = 2'h0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (!e.lanes_n[i]) begin
        f = 2'(i);
      end
    end
    if (e.width == PW_16) begin
      f = {f[1], 1'b0};
    end else if (e.width == PW_32) begin
      f = 2'h0;
    end
    return f;
  endfunction

  // --------------------------------------------------------------------------
  // half-clock phase: high from falling edge to next rising edge
  // --------------------------------------------------------------------------
  // a single falling-edge flop; every half-clock event is derived from it so
  // that no other state needs a second clock edge
  logic rise_tog_r;
  logic fall_tog_r;
  logic second_half;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_tog_r <= 1'b0;
    end else begin
      rise_tog_r <= ~rise_tog_r;
    end
  end

  always_ff @(negedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fall_tog_r <= 1'b0;
    end else begin
      fall_tog_r <= rise_tog_r;
    end
  end

  assign second_half = (rise_tog_r == fall_tog_r);

  // --------------------------------------------------------------------------
  // configuration capture
  // --------------------------------------------------------------------------
  logic       long_mode_r;
  logic       strap_taken_r;
  logic [1:0] pin_dir_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      long_mode_r   <= LONG_MODE_RESET;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      long_mode_r   <= long_address_mode_i;
      strap_taken_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_dir_r <= DIR_RESET;
    end else begin
      pin_dir_r <= pin_direction_ctrl_i;
    end
  end

  // --------------------------------------------------------------------------
  // write buffer
  // --------------------------------------------------------------------------
  wb_entry_t        wb_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0]   fill_r;
  logic             full;
  logic             accept;
  logic             start;
  logic             stalled_r;
  wr_state_t        st_r;

  assign full   = (fill_r == FULL_CNT);
  assign accept = store_valid_i & ~full;
  assign start  = (st_r == ST_IDLE) & (fill_r != '0) & ~hi_prio_req_i & ~ext_busy_i;

  always_ff @(posedge core_clk_i) begin
    if (accept) begin
      wb_mem[wr_ptr_r] <= store_entry_i;
    end
  end

  // head leaves at the opening edge, so a stalled core gets its slot while
  // the memory system may still be holding the bus for many cycles
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r   <= '0;
    end else begin
      if (accept) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (start) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      fill_r <= fill_r + {{PTR_W{1'b0}}, accept} - {{PTR_W{1'b0}}, start};
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stalled_r <= 1'b0;
    end else begin
      stalled_r <= store_valid_i & full;
    end
  end

  assign store_stall_o    = store_valid_i & full;
  assign store_fixup_o    = accept & stalled_r;
  assign buffer_pending_o = (fill_r != '0);
  assign buffer_drained_o = (fill_r == '0);

  // --------------------------------------------------------------------------
  // write engine
  // --------------------------------------------------------------------------
  wb_entry_t        hold_r;
  logic             busy_r;
  logic             dly_busy_r;
  logic             tail_r;
  logic             ale_r;
  logic             acked_r;
  logic             cyc1_r;
  logic             peri_r;
  logic             own_r;
  logic             last_n_r;
  logic [2:0]       datums_r;
  logic [2:0]       idx_r;
  logic [LO_W-1:0]  lo_r;
  logic             ack_seen;
  logic             fail_seen;
  logic             final_ack;
  logic             term;
  logic             watching;

  assign watching  = (st_r == ST_ADDR) | (st_r == ST_DATA);
  assign ack_seen  = watching & ~ack_n_i;
  assign fail_seen = watching & ~transfer_fail_n_i;
  assign final_ack = ack_seen & (idx_r + 3'h1 == datums_r);
  assign term      = fail_seen | final_ack;

  always_ff @(posedge core_clk_i) begin
    if (start) begin
      hold_r <= wb_mem[rd_ptr_r];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r     <= ST_IDLE;
      busy_r   <= 1'b0;
      ale_r    <= 1'b0;
      acked_r  <= 1'b0;
      tail_r   <= 1'b0;
      cyc1_r   <= 1'b0;
      last_n_r <= 1'b1;
      datums_r <= ONE_DATUM;
      idx_r    <= 3'h0;
      lo_r     <= '0;
    end else begin
      acked_r <= ack_seen | fail_seen;
      tail_r  <= term;
      cyc1_r  <= (st_r == ST_ADDR) & ~term;
      unique case (st_r)
        ST_IDLE: begin
          if (start) begin
            st_r     <= ST_ADDR;
            busy_r   <= 1'b1;
            ale_r    <= 1'b1;
            datums_r <= datum_count(wb_mem[rd_ptr_r]);
            idx_r    <= 3'h0;
            lo_r     <= {wb_mem[rd_ptr_r].addr[3:2], first_lane(wb_mem[rd_ptr_r])};
            last_n_r <= ~(datum_count(wb_mem[rd_ptr_r]) == ONE_DATUM);
          end
        end
        ST_ADDR, ST_DATA: begin
          ale_r <= 1'b0;
          if (term) begin
            // fail wins over a simultaneous ack; unsent data dropped
            st_r     <= ST_IDLE;
            busy_r   <= 1'b0;
            last_n_r <= 1'b1;
          end else begin
            st_r <= ST_DATA;
            if (ack_seen) begin
              idx_r <= idx_r + 3'h1;
              lo_r  <= lo_r + ((hold_r.width == PW_16) ? STEP_HALF : STEP_BYTE);
              if (idx_r + 3'h2 == datums_r) begin
                last_n_r <= 1'b0;
              end
            end
          end
        end
        default: begin
          st_r   <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dly_busy_r <= 1'b0;
      peri_r     <= 1'b0;
    end else begin
      dly_busy_r <= busy_r & ~start;
      peri_r     <= (cyc1_r | peri_r) & ~term & busy_r;
    end
  end

  // bus stays ours after a write; only a higher-priority request while idle drops it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      own_r <= 1'b0;
    end else if (start) begin
      own_r <= 1'b1;
    end else if ((st_r == ST_IDLE) & hi_prio_req_i) begin
      own_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // same-page hint
  // --------------------------------------------------------------------------
  logic [PAGE_W-1:0] page_r;
  logic              page_valid_r;
  logic              hint_n_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_r       <= '0;
      page_valid_r <= 1'b0;
      hint_n_r     <= 1'b1;
    end else begin
      if (start) begin
        page_r       <= wb_mem[rd_ptr_r].addr[ADDR_W-1:PAGE_LSB];
        page_valid_r <= 1'b1; // set wins over a read or DMA in the same cycle
        hint_n_r     <= ~(page_valid_r & ~read_or_dma_seen_i
                          & (page_r == wb_mem[rd_ptr_r].addr[ADDR_W-1:PAGE_LSB]));
      end else if (read_or_dma_seen_i) begin
        page_valid_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------------
  logic addr_on_bus;

  // long mode keeps the address a full clock; normal mode swaps at strobe fall
  assign addr_on_bus = ale_r & (long_mode_r | ~second_half);
  assign ad_o        = addr_on_bus ? {hold_r.addr[ADDR_W-1:LANES], hold_r.lanes_n}
                                   : hold_r.data;
  assign ad_oe_o     = own_r;
  assign ale_o       = ale_r & ~second_half;
  assign wr_n_o      = ~busy_r;
  assign wr_busy_o   = busy_r;
  assign addr_lo_o   = lo_r;
  assign last_n_o    = last_n_r;
  assign same_page_hint_n_o = hint_n_r;

  // releases for the half clock after each ack, including the final one
  assign memory_pulse_n_o = ~(mem_mask_i.wr & dly_busy_r & ~(acked_r & second_half));

  assign long_data_gate_n_oe_o = pin_dir_r[DIR_GATE_BIT];
  assign long_data_gate_n_o    = ~(gate_mask_i.wr & pin_dir_r[DIR_GATE_BIT]
                                   & dly_busy_r & ~(tail_r & second_half));

  // the live ack/fail look in the second half of clock two keeps the pulse
  // off in a two-clock write; the far end must drive them before that edge
  assign periph_pulse_n_oe_o = pin_dir_r[DIR_PERI_BIT];
  assign periph_pulse_n_o    = ~(periph_mask_i.wr & pin_dir_r[DIR_PERI_BIT] & busy_r
                                 & (peri_r | (cyc1_r & second_half & ack_n_i
                                              & transfer_fail_n_i)));

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  AST_START_WHEN_READY: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (st_r == ST_IDLE) && buffer_pending_o && !hi_prio_req_i && !ext_busy_i |=> !wr_n_o && ale_r)
    else $error("write did not start when bus was free");

  AST_OPEN_EDGE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $fell(wr_n_o) |-> ale_r && ad_oe_o && (st_r == ST_ADDR))
    else $error("opening edge lacks latch strobe or bus drive");

  AST_STROBE_RELEASE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    term |=> wr_n_o ##1 (tail_r == 1'b0 || !wr_n_o))
    else $error("store strobe not released after termination");

  AST_NEXT_START: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    term && buffer_pending_o |=> start || hi_prio_req_i || ext_busy_i)
    else $error("next write did not open one clock after termination");

  AST_FAIL_WINS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    watching && !transfer_fail_n_i && !ack_n_i && !final_ack |=> wr_n_o && last_n_o)
    else $error("fail with ack did not end the write");

  AST_LAST_SINGLE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $fell(wr_n_o) && (datums_r == ONE_DATUM) |-> !last_n_o)
    else $error("final flag missing on single-datum write");

  AST_FULL_STALL: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    store_valid_i && (fill_r == FULL_CNT) && !start |=> (fill_r == FULL_CNT) && $past(store_stall_o))
    else $error("store into full buffer not stalled");

  AST_ENTRY_FREED: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    start && !accept |=> (fill_r == $past(fill_r) - 1'b1) && (hold_r == $past(wb_mem[rd_ptr_r])))
    else $error("entry not released when write started");

  AST_PERIPH_MIN: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    peri_r |-> $past(busy_r, 1) && $past(busy_r, 2) && dly_busy_r)
    else $error("peripheral pulse held in a short write");

  AST_MEM_ONE_CLOCK: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $fell(wr_n_o) |-> !dly_busy_r || tail_r ##1 dly_busy_r)
    else $error("memory pulse window not opened one clock in");

  AST_NO_TURNAROUND: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    tail_r |-> ad_oe_o)
    else $error("bus released right after a write");

  AST_GATE_RESET_INPUT: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (pin_dir_r == DIR_RESET) |-> !long_data_gate_n_oe_o && !periph_pulse_n_oe_o)
    else $error("gate pin driven while configured as input");

  COV_BURST_DONE: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    final_ack && (datums_r > ONE_DATUM));
  COV_FAIL_END: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    fail_seen ##1 start);
  COV_FIXUP: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    store_fixup_o);
  COV_PERIPH: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    peri_r && periph_mask_i.wr);

endmodule // cpu_bus_write_interface
`default_nettype wire

/* File: verif/mem_ctrl_model.sv */
// memory controller model that acknowledges or fails bus writes
`timescale 1ns/100ps
`default_nettype none
module mem_ctrl_model (
  input  wire logic        core_clk_i,
  input  wire logic        wr_n_i,
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  waits_i,
  input  wire logic [2:0]  fail_at_i,
  output logic             ack_n_o,
  output logic             transfer_fail_n_o
);
  // ----
  // acknowledge engine
  // ----
  logic [3:0]  cnt = 4'h0;
  logic [2:0]  dat = 3'h0;
  logic        w;
  logic [31:0] got [$];
  logic        ack_q  = 1'b1;
  logic        fail_q = 1'b1;
  // one driver per pin; the engine below owns both
  assign ack_n_o           = ack_q;
  assign transfer_fail_n_o = fail_q;
  // changes land just after each rising edge; a failed datum is not kept
  always @(posedge core_clk_i) begin
    w = wr_n_i;
    #1;
    if (!w && !ack_q && fail_q) got.push_back(ad_i);
    if (!ack_q) begin
      cnt = 4'h0;
      dat = dat + 3'h1;
    end
    ack_q = 1'b1;
    fail_q = 1'b1;
    if (wr_n_i) begin
      cnt = 4'h0;
      dat = 3'h0;
    end else if (cnt != waits_i) cnt = cnt + 4'h1;
    else begin
      ack_q = 1'b0;
      fail_q = !(dat + 3'h1 == fail_at_i);
    end
  end
endmodule // mem_ctrl_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the processor-side bus write path
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cpu_wr_pkg::*;
  // ----
  // stimulus and checks
  // ----
  logic clk = 1'b0, rst_n = 1'b0, sv = 1'b0, hp = 1'b0, eb = 1'b0, rds = 1'b0, lm = 1'b0;
  logic hv = 1'b0, hpr = 1'b0;
  logic [1:0] dir = 2'h0;
  logic [3:0] waits = 4'h0;
  logic [2:0] fat = 3'h0;
  strobe_mask_t gm = '{1'b1, 1'b1}, mm = '{1'b1, 1'b1}, pm = '{1'b1, 1'b1};
  wb_entry_t ent = '0;
  logic stall, fix, pend, drn, busy, oe, ale, wr_n, last_n, hint_n, mp_n, pp_n, pp_oe, gd_n, gd_oe, ack_n, fail_n;
  logic [31:0] ad, pa;
  logic [3:0] alo;
  int n_mismatch = 0, tests_run = 0, mpc, ppc, stl, fx, k;
  always #5 clk = ~clk;
  logic mp_q = 1'b1, pp_q = 1'b1;
  // falls counted on settled values 1 ns past each clock edge; zero-width glitches ignored
  always @(clk) begin
    #1;
    if (mp_q && !mp_n) mpc++;
    if (pp_q && !pp_n) ppc++;
    mp_q = mp_n;
    pp_q = pp_n;
  end
  cpu_bus_write_interface cpu_bus_write_interface_inst (.core_clk_i(clk), .arst_n_i(rst_n),
    .store_valid_i(sv), .store_entry_i(ent), .store_stall_o(stall), .store_fixup_o(fix),
    .buffer_pending_o(pend), .buffer_drained_o(drn), .hi_prio_req_i(hp), .ext_busy_i(eb),
    .read_or_dma_seen_i(rds), .wr_busy_o(busy), .long_address_mode_i(lm), .pin_direction_ctrl_i(dir),
    .gate_mask_i(gm), .mem_mask_i(mm), .periph_mask_i(pm), .ad_o(ad), .ad_oe_o(oe), .ale_o(ale),
    .wr_n_o(wr_n), .addr_lo_o(alo), .last_n_o(last_n), .same_page_hint_n_o(hint_n), .memory_pulse_n_o(mp_n),
    .periph_pulse_n_i(pp_oe ? pp_n : 1'b1), .periph_pulse_n_o(pp_n), .periph_pulse_n_oe_o(pp_oe),
    .long_data_gate_n_i(gd_oe ? gd_n : 1'b1), .long_data_gate_n_o(gd_n), .long_data_gate_n_oe_o(gd_oe),
    .ack_n_i(ack_n), .transfer_fail_n_i(fail_n));
  mem_ctrl_model mem_ctrl_model_inst (.core_clk_i(clk), .wr_n_i(wr_n), .ad_i(ad), .waits_i(waits),
    .fail_at_i(fat), .ack_n_o(ack_n), .transfer_fail_n_o(fail_n));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one store, then the whole bus write watched edge by edge
  task automatic wr(input logic [31:0] a, d, input logic [1:0] w, input logic [3:0] l, input int wt, fa);
    int n, dn, len, q;
    logic lst;
    logic [3:0] lo;
    dn = (w == PW_32) ? 1 : (w == PW_16) ? int'(l[1:0] != 2'h3) + int'(l[3:2] != 2'h3) : 4 - $countones(l);
    q = (fa != 0) ? fa : dn;
    // first datum address: lowest enabled byte, or half, of the word
    lo = {a[3:2], 2'h0};
    for (int i = 3; i >= 0; i--) begin
      if (!l[i] && w != PW_32) lo[1:0] = (w == PW_16) ? 2'(i & 2) : 2'(i);
    end
    @(posedge clk);
    waits <= wt[3:0];
    fat <= fa[2:0];
    sv <= 1'b1;
    ent <= '{a, d, l, w};
    @(posedge clk);
    sv <= 1'b0;
    n = 0;
    while (wr_n !== 1'b0 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    mpc = 0;
    ppc = 0;
    lst = last_n;
    chk("start", 1, hpr ? n > 8 : n == 1);
    chk("ale", 1, ale);
    chk("addr", {a[31:4], l}, ad);
    chk("drive", 1, oe);
    chk("hint", !(hv && a[31:8] == pa[31:8]), hint_n);
    chk("last", dn != 1, last_n);
    chk("addr_lo", lo, alo);
    @(negedge clk);
    #1;
    chk("ale_fall", 0, ale);
    chk("half", lm ? {a[31:4], l} : d, ad);
    len = 0;
    do begin
      @(posedge clk);
      #1;
      len++;
      if (len == 1) begin
        chk("data", d, ad);
        chk("gate", !(dir[0] && gm.wr), gd_n);
        chk("mem_pulse", 0, mp_n);
      end
      if (wr_n === 1'b0) lst = last_n;
    end while (wr_n === 1'b0 && len < 60);
    chk("length", q * (wt + 1), len);
    chk("last_end", q != dn, lst);
    chk("last_rel", 1, last_n);
    chk("addr_lo_end", lo + (q - 1) * ((w == PW_16) ? 2 : 1), alo);
    @(negedge clk);
    #1;
    chk("gate_rel", 1, gd_n);
    chk("pulses", q, mpc);
    if (dn == 1) chk("periph", dir[1] && len >= 3, ppc != 0);
    chk("acked", (fa != 0) ? fa - 1 : dn, mem_ctrl_model_inst.got.size());
    mem_ctrl_model_inst.got.delete();
    pa = a;
    hv = 1'b1;
    $display("test write %h done", a);
  endtask
  // holds the request until taken; the caller lowers it
  task automatic push(input logic [31:0] a, d);
    logic s, seen;
    seen = 1'b0;
    sv <= 1'b1;
    ent <= '{a, d, 4'h0, PW_32};
    do begin
      @(negedge clk);
      s = stall;
      seen |= s;
      if (fix === 1'b1) begin
        fx++;
        chk("fixup_busy", 1, busy);
      end
      @(posedge clk);
    end while (s !== 1'b0);
    stl += int'(seen);
  endtask
  initial begin
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      lm <= m[0];
      gm <= '{1'b1, m[0]};
      dir <= 2'h0;
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      chk("rst_wr", 1, wr_n);
      chk("rst_gate_oe", 0, gd_oe);
      chk("rst_pp_oe", 0, pp_oe);
      rst_n <= 1'b1;
      hv = 1'b0;
      @(posedge clk);
      dir <= 2'h3;
      wr(32'h1230, 32'hdeadbeef, PW_32, 4'h0, 0, 0);
      wr(32'h1244, 32'h12345678, PW_32, 4'h3, 2, 0);
      @(posedge clk);
      rds <= 1'b1;
      @(posedge clk);
      rds <= 1'b0;
      hv = 1'b0;
      wr(32'h1248, 32'h0badf00d, PW_32, 4'h0, 1, 0);
      wr(32'h2000, 32'h11112222, PW_16, 4'h0, 0, 0);
      wr(32'h2004, 32'h33445566, PW_8, 4'h0, 1, 0);
      wr(32'h2008, 32'h778899aa, PW_8, 4'h1, 0, 2);
      wr(32'h200c, 32'hcafe0001, PW_32, 4'h0, 1, 1);
      @(posedge clk);
      hpr = 1'b1;
      if (m == 1) eb <= 1'b1;
      else hp <= 1'b1;
      fork
        begin
          repeat (12) @(posedge clk);
          hp <= 1'b0;
          eb <= 1'b0;
        end
      join_none
      wr(32'h3000, 32'h5a5a5a5a, PW_32, 4'h0, 0, 0);
      hpr = 1'b0;
      // slow first write lets four more queue; the sixth must wait
      @(posedge clk);
      waits <= 4'hf;
      fat <= 3'h0;
      stl = 0;
      fx = 0;
      for (int i = 0; i < 6; i++) push(32'h4000 + i * 4, 32'hc0 + i);
      sv <= 1'b0;
      chk("pending", 1, pend);
      chk("stalls", 1, stl);
      chk("fixups", 1, fx);
      k = 0;
      while (drn !== 1'b1 && k < 400) begin
        @(posedge clk);
        k++;
      end
      repeat (20) @(posedge clk);
      for (int i = 0; i < 6; i++) chk("order", 32'hc0 + i, mem_ctrl_model_inst.got[i]);
      mem_ctrl_model_inst.got.delete();
      dir <= 2'h0;
      repeat (2) @(posedge clk);
      #1;
      chk("gate_in", 0, gd_oe);
      chk("pp_in", 0, pp_oe);
      $display("test mode %0d done", m);
    end
    complete_run;
  end
  // whole run is a few hundred cycles; ten thousand cycles means a hang
  initial begin
    #100000;
    n_mismatch++;
    complete_run;
  end
endmodule // tb
`default_nettype wire
